/* inc/pfs_pkg.sv */
`default_nettype none
package pfs_pkg;
  // Clock rate and derived one-millisecond tick
  localparam int unsigned CLK_HZ = 250_000_000;
  localparam int unsigned MS_NS = 1_000_000;
  localparam int unsigned CLK_NS = 4;
  localparam int unsigned MS_CYCLES = MS_NS / CLK_NS;
  // Over-power timing in milliseconds
  localparam int unsigned OP_BAND_MS = 20_000;
  localparam int unsigned OP_HIGH_MS = 1_000;
  // Zero-reference hold when leaving crowbar, in milliseconds
  localparam int unsigned VZERO_MS = 20;
  // Fault classes, index into the fault vector
  localparam int unsigned NFLT = 10;
  localparam int unsigned F_CSENS = 0;
  localparam int unsigned F_DCLINK = 1;
  localparam int unsigned F_CROWBAR = 2;
  localparam int unsigned F_OTEMP = 3;
  localparam int unsigned F_OUT_OC = 4;
  localparam int unsigned F_IN_OC = 5;
  localparam int unsigned F_OPOWER = 6;
  localparam int unsigned F_FAN = 7;
  localparam int unsigned F_EXTIL = 8;
  localparam int unsigned F_PARAL = 9;
  // First-fault code: 0 means none, else class index plus one
  localparam logic [3:0] FCODE_NONE = 4'h0;
  // Thresholds, in sensor units (power W, current A, temp C, mV)
  localparam logic [15:0] P_RATED_W = 16'h026B;
  localparam logic [15:0] P_CONT_W = 16'h0278;
  localparam logic [15:0] P_BAND_W = 16'h028B;
  localparam logic [15:0] OV_MV = 16'h30D4;
  localparam logic [7:0] I_FULL_A = 8'h78;
  localparam logic [7:0] T_DCDC_ON = 8'h27;
  localparam logic [7:0] T_DISS_ON = 8'h2D;
  localparam logic [7:0] T_FAN_OFF = 8'h21;
  localparam logic [7:0] FAN_MAX = 8'hFF;
  localparam logic [7:0] FAN_ZERO = 8'h00;
  // Supervisor states
  typedef enum logic [1:0] {
    PFS_OFF = 2'b00,
    PFS_RELEASE = 2'b01,
    PFS_ON = 2'b11
  } pfs_state_e;
endpackage : pfs_pkg
`default_nettype wire

/* rtl/pfs_timer.sv */
`timescale 1ns/100ps
`default_nettype none
// Millisecond duration counter, restarts whenever run drops
module pfs_timer
  import pfs_pkg::*;
(
  input wire logic clk, // System clock
  input wire logic rst_n, // Synchronous reset, low
  input wire logic tick, // One-millisecond enable
  input wire logic run, // Condition being timed
  input wire logic [15:0] limit, // Duration in ms
  output logic expired // Condition lasted the limit
);
  logic [15:0] cnt_q;
  logic [15:0] cnt_d;
  wire at_limit = (cnt_q >= limit);

  // Hold at limit, clear when not running
  assign cnt_d = !run ? 16'h0000 :
                 (tick && !at_limit) ? cnt_q + 16'h0001 : cnt_q;
  assign expired = run && at_limit;

  // Counter register
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cnt_q <= 16'h0000;
    end else begin
      cnt_q <= cnt_d;
    end
  end
endmodule : pfs_timer
`default_nettype wire

/* rtl/pfs_supervisor.sv */
`timescale 1ns/100ps
`default_nettype none
// What this block does
// - Any of ten fault classes disables output
// - DC link fault: bulk off, malfunction, overcurrent
// - Fan fault: blocked or below commanded speed
// - Display only the first detected fault
// - Unlimited operation up to two percent over
// - Two to five percent over trips after 20s
// - Table conflict resolved: 20 s band used
// - Over five percent trips after one second
// - AC/DC fans on with bulk, follow power unless sinking
// - DC/DC fans follow current, full at 120A
// - DC/DC fans: hysteresis 39 up, 33 off
// - Dissipative fans on sinking; 45 up, 33 off
// - Master detects slave, else standalone
// - Parallel fault on link loss or mismatch
// - Closed enable contact enables output
// - Interlock contact faults, polarity selectable
// - Closed reset contact clears faults whose cause is gone
// - Fault contact closed when fault free
// - Changeover relay follows output enable
// - Settings ignore interlock, enable, reset contacts
// - Crowbar on disable, overvoltage or fault
// - Leave crowbar only on command, no faults
// - Button toggles output, tries fault reset
// - Auto enable after blackout with bulk on
module pfs_supervisor
  import pfs_pkg::*;
(
  input wire logic clk, // System clock, 250 MHz
  input wire logic rst_n, // Synchronous reset, low
  input wire logic bulk_on, // Bulk mains switch on
  input wire logic csens_err, // Current sensor malfunction
  input wire logic bulk_err, // Bulk converter malfunction
  input wire logic dclink_oc, // DC link overcurrent
  input wire logic crowbar_err, // Crowbar malfunction
  input wire logic otemp, // Section over temperature
  input wire logic out_oc, // Output overcurrent
  input wire logic in_oc, // Input overcurrent
  input wire logic [7:0] fan_blocked, // Per-fan stall
  input wire logic [7:0] fan_slow, // Per-fan below target
  input wire logic [15:0] vout_mv, // Output voltage magnitude
  input wire logic [15:0] pout_w, // Output power magnitude
  input wire logic sinking, // Power flows from load
  input wire logic [7:0] iout_a, // Output current magnitude
  input wire logic [7:0] t_dcdc, // DC/DC section temperature
  input wire logic [7:0] t_diss, // Dissipative section temp
  input wire logic is_master, // Configured as master
  input wire logic slave_present, // Slave answers on link
  input wire logic link_err, // Parallel link failure
  input wire logic cfg_mismatch, // Inconsistent unit config
  input wire logic button, // Front toggle, one-cycle press
  input wire logic enable_contact, // Enable dry contact closed
  input wire logic intlk_contact, // Interlock contact closed
  input wire logic reset_contact, // Fault reset contact closed
  input wire logic intlk_invert, // Interlock active when open
  input wire logic intlk_ignore, // Ignore interlock input
  input wire logic enable_ignore, // Ignore enable contact
  input wire logic reset_ignore, // Ignore reset contact
  output logic out_enable, // DC/DC stage enabled
  output logic crowbar_on, // Output short active
  output logic vref_zero, // Force voltage reference to 0
  output logic fault_contact_closed, // Closed while fault free
  output logic relay_no_closed, // Normally-open tap closed
  output logic relay_nc_closed, // Normally-closed tap closed
  output logic [9:0] fault_q_o, // Latched fault classes
  output logic [3:0] first_fault, // Code of first fault
  output logic slave_active, // Master running with slave
  output logic [7:0] fan_acdc, // AC/DC fan speed
  output logic [7:0] fan_dcdc, // DC/DC fan speed
  output logic [7:0] fan_diss // Dissipative fan speed
);
  pfs_state_e st_q;
  pfs_state_e st_d;
  logic [NFLT-1:0] flt_q;
  logic [NFLT-1:0] flt_d;
  logic [NFLT-1:0] cause;
  logic [3:0] first_q;
  logic [3:0] first_d;
  logic [17:0] div_q;
  logic tick_q;
  logic [15:0] zero_q;
  logic en_prev_q;
  logic rst_prev_q;
  logic boot_q;
  logic dcdc_hot_q;
  logic diss_hot_q;
  logic band_exp;
  logic high_exp;
  logic ov_q;

  // Millisecond enable from the system clock
  wire div_end = (div_q == 18'(MS_CYCLES - 1));
  always_ff @(posedge clk) begin
    if (!rst_n || div_end) begin
      div_q <= 18'h00000;
    end else begin
      div_q <= div_q + 18'h00001;
    end
  end
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      tick_q <= 1'b0;
    end else begin
      tick_q <= div_end;
    end
  end

  // Over-power bands
  wire in_band = (pout_w > P_CONT_W) && (pout_w <= P_BAND_W);
  wire in_high = (pout_w > P_BAND_W);

  // Band timer, 20 s resolves the table conflict
  pfs_timer u_band (
    .clk(clk),
    .rst_n(rst_n),
    .tick(tick_q),
    .run(in_band || in_high),
    .limit(16'(OP_BAND_MS)),
    .expired(band_exp)
  );

  // High band timer
  pfs_timer u_high (
    .clk(clk),
    .rst_n(rst_n),
    .tick(tick_q),
    .run(in_high),
    .limit(16'(OP_HIGH_MS)),
    .expired(high_exp)
  );

  // Interlock polarity and ignore setting
  wire intlk_act = !intlk_ignore && (intlk_contact ^ intlk_invert);

  // Raw fault causes
  always_comb begin
    cause = '0;
    cause[F_CSENS] = csens_err;
    cause[F_DCLINK] = !bulk_on || bulk_err || dclink_oc;
    cause[F_CROWBAR] = crowbar_err || ov_q;
    cause[F_OTEMP] = otemp;
    cause[F_OUT_OC] = out_oc;
    cause[F_IN_OC] = in_oc;
    cause[F_OPOWER] = band_exp || high_exp;
    cause[F_FAN] = |(fan_blocked | fan_slow);
    cause[F_EXTIL] = intlk_act;
    cause[F_PARAL] = link_err || cfg_mismatch;
  end

  // Contact edges and reset request
  wire en_rise = enable_contact && !en_prev_q && !enable_ignore;
  wire rst_rise = reset_contact && !rst_prev_q && !reset_ignore;
  wire btn_off = button && (st_q == PFS_ON);
  wire btn_on = button && (st_q == PFS_OFF);
  wire reset_req = rst_rise || btn_on;

  // Faults latch; clear only on reset with cause gone
  assign flt_d = cause | (flt_q & ~(reset_req ? ~cause : '0));
  wire any_flt = |flt_d;

  // First detected fault, lowest index wins a tie
  logic [3:0] new_code;
  always_comb begin
    new_code = FCODE_NONE;
    for (int i = NFLT - 1; i >= 0; i--) begin
      if (flt_d[i] && !flt_q[i]) begin
        new_code = 4'(i + 1);
      end
    end
  end
  // Lowest-index fault still held, shown once the first one clears
  logic [3:0] keep_code;
  always_comb begin
    keep_code = FCODE_NONE;
    for (int i = NFLT - 1; i >= 0; i--) begin
      if (flt_d[i] && flt_q[i]) begin
        keep_code = 4'(i + 1);
      end
    end
  end
  wire [3:0] pick_code = (keep_code != FCODE_NONE) ? keep_code : new_code;
  assign first_d = !any_flt ? FCODE_NONE :
                   (first_q == FCODE_NONE ||
                    !flt_d[first_q - 4'h1]) ? pick_code : first_q;

  // Enable request: contact, button, or power-up recovery
  wire on_req = en_rise || btn_on || (boot_q && bulk_on);

  // Output state machine
  always_comb begin
    st_d = st_q;
    unique case (st_q)
      PFS_OFF: begin
        if (on_req && !any_flt) begin
          st_d = PFS_RELEASE;
        end
      end
      PFS_RELEASE: begin
        if (any_flt) begin
          st_d = PFS_OFF;
        end else if (zero_q == 16'(VZERO_MS)) begin
          st_d = PFS_ON;
        end
      end
      PFS_ON: begin
        if (any_flt || btn_off) begin
          st_d = PFS_OFF;
        end
      end
    endcase
  end

  // State, faults, edges and flags
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      st_q <= PFS_OFF;
      flt_q <= '0;
      first_q <= FCODE_NONE;
      en_prev_q <= 1'b0;
      rst_prev_q <= 1'b0;
      boot_q <= 1'b1;
      ov_q <= 1'b0;
    end else begin
      st_q <= st_d;
      flt_q <= flt_d;
      first_q <= first_d;
      en_prev_q <= enable_contact;
      rst_prev_q <= reset_contact;
      boot_q <= boot_q && !bulk_on;
      ov_q <= (vout_mv > OV_MV);
    end
  end

  // Zero-reference hold counter during release
  always_ff @(posedge clk) begin
    if (!rst_n || st_q != PFS_RELEASE) begin
      zero_q <= 16'h0000;
    end else if (tick_q && zero_q != 16'(VZERO_MS)) begin
      zero_q <= zero_q + 16'h0001;
    end
  end

  // Hysteresis of the DC/DC and dissipative sections
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      dcdc_hot_q <= 1'b0;
      diss_hot_q <= 1'b0;
    end else begin
      if (t_dcdc > T_DCDC_ON) begin
        dcdc_hot_q <= 1'b1;
      end else if (t_dcdc < T_FAN_OFF) begin
        dcdc_hot_q <= 1'b0;
      end
      if (t_diss > T_DISS_ON) begin
        diss_hot_q <= 1'b1;
      end else if (t_diss < T_FAN_OFF) begin
        diss_hot_q <= 1'b0;
      end
    end
  end

  // Fan speed targets
  wire [15:0] i_scaled = 16'(iout_a) * 16'h00FF / 16'(I_FULL_A);
  wire [7:0] dcdc_lin = (iout_a >= I_FULL_A) ? FAN_MAX : i_scaled[7:0];
  wire [7:0] dcdc_spd = dcdc_hot_q ? FAN_MAX : dcdc_lin;
  wire [7:0] diss_spd = diss_hot_q ? FAN_MAX :
                        (sinking ? 8'h80 : FAN_ZERO);
  wire [7:0] pw_spd = (pout_w >= P_BAND_W) ? FAN_MAX : pout_w[9:2];
  wire [7:0] acdc_spd = !bulk_on ? FAN_ZERO :
                        (sinking ? 8'h40 :
                         (pw_spd < 8'h40 ? 8'h40 : pw_spd));

  // Registered outputs
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      out_enable <= 1'b0;
      crowbar_on <= 1'b1;
      vref_zero <= 1'b1;
      fault_contact_closed <= 1'b0;
      relay_no_closed <= 1'b0;
      relay_nc_closed <= 1'b1;
      fault_q_o <= '0;
      first_fault <= FCODE_NONE;
      slave_active <= 1'b0;
      fan_acdc <= FAN_ZERO;
      fan_dcdc <= FAN_ZERO;
      fan_diss <= FAN_ZERO;
    end else begin
      out_enable <= (st_d == PFS_ON);
      crowbar_on <= (st_d == PFS_OFF) || ov_q || any_flt;
      vref_zero <= (st_d != PFS_ON);
      fault_contact_closed <= !any_flt;
      relay_no_closed <= (st_d == PFS_ON);
      relay_nc_closed <= (st_d != PFS_ON);
      fault_q_o <= flt_d;
      first_fault <= first_d;
      slave_active <= is_master && slave_present && !link_err;
      fan_acdc <= acdc_spd;
      fan_dcdc <= dcdc_spd;
      fan_diss <= diss_spd;
    end
  end
endmodule : pfs_supervisor
`default_nettype wire

/* verif/pfs_supervisor_checker.sv */
`timescale 1ns/100ps
`default_nettype none
// Port-level checks on the supervisor outputs
module pfs_supervisor_checker
  import pfs_pkg::*;
(
  input wire logic clk, // Clock
  input wire logic rst_n, // Reset, low
  input wire logic bulk_on, // Bulk switch
  input wire logic csens_err, // Sensor cause
  input wire logic [15:0] vout_mv, // Voltage
  input wire logic [7:0] fan_blocked, // Stalls
  input wire logic intlk_contact, // Interlock
  input wire logic intlk_invert, // Polarity
  input wire logic intlk_ignore, // Ignore
  input wire logic button, // Toggle
  input wire logic reset_contact, // Reset
  input wire logic out_enable, // Enabled
  input wire logic crowbar_on, // Short
  input wire logic vref_zero, // Zero ref
  input wire logic fault_contact_closed, // Fault free
  input wire logic relay_no_closed, // NO tap
  input wire logic relay_nc_closed, // NC tap
  input wire logic [9:0] fault_q_o, // Faults
  input wire logic [3:0] first_fault // First code
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  // Relations between causes and outputs
  chk_relay_pair: assert property (
    relay_no_closed == out_enable && relay_nc_closed != relay_no_closed)
    else $error("relay taps wrong");
  chk_fault_contact: assert property (
    $past(rst_n) |-> fault_contact_closed == (fault_q_o == 10'h000))
    else $error("fault contact wrong");
  chk_fault_crowbar: assert property (
    fault_q_o != 10'h000 |-> crowbar_on && !out_enable)
    else $error("fault without crowbar");
  chk_dclink_bulk: assert property (
    !bulk_on |=> fault_q_o[F_DCLINK])
    else $error("bulk off not flagged");
  chk_ovolt_trip: assert property (
    vout_mv > OV_MV |-> ##[1:2] crowbar_on)
    else $error("overvoltage missed");
  chk_fan_stall: assert property (
    fan_blocked != 8'h00 |=> fault_q_o[F_FAN])
    else $error("fan stall missed");
  chk_intlk_trip: assert property (
    (intlk_contact ^ intlk_invert) && !intlk_ignore |=> fault_q_o[F_EXTIL])
    else $error("interlock missed");
  chk_latch_hold: assert property (
    $fell(fault_q_o[F_CSENS]) |-> $past(button || reset_contact)
      && !$past(csens_err))
    else $error("fault cleared early");
  chk_enable_clean: assert property (
    $rose(out_enable) |-> $past(vref_zero) && fault_q_o == 10'h000)
    else $error("enable with fault");
  chk_first_none: assert property (
    fault_q_o == 10'h000 |-> first_fault == FCODE_NONE)
    else $error("code without fault");
  // Main scenarios reached
  cov_intlk: cover property (fault_q_o[F_EXTIL]);
  cov_release: cover property (!crowbar_on);
  cov_clear: cover property ($fell(fault_q_o[F_CSENS]));
endmodule : pfs_supervisor_checker
`default_nettype wire

/* verif/pfs_plant.sv */
`timescale 1ns/100ps
`default_nettype none
// Plant side of the contact connector, prompt or slow
module pfs_plant
  import pfs_pkg::*;
(
  input wire logic clk, // Clock
  input wire logic slow, // Two extra cycles lag
  input wire logic want_en, // Close enable
  input wire logic want_il, // Close interlock
  input wire logic want_rst, // Close reset
  output logic enable_contact, // Enable closed
  output logic intlk_contact, // Interlock closed
  output logic reset_contact // Reset closed
);
  logic [8:0] pipe_q;
  // Requests travel through a short lag line
  always_ff @(posedge clk) begin
    pipe_q <= {pipe_q[5:0], want_en, want_il, want_rst};
  end
  // Interlock stays open unless asked
  assign {enable_contact, intlk_contact, reset_contact} =
    slow ? pipe_q[8:6] : pipe_q[2:0];
endmodule : pfs_plant
`default_nettype wire

/* verif/tb_pfs_supervisor.sv */
`timescale 1ns/100ps
`default_nettype none
module tb_pfs_supervisor
  import pfs_pkg::*;
;
  logic clk = 0, rst_n = 0, bulk_on = 1, csens_err = 0, bulk_err = 0;
  logic dclink_oc = 0, crowbar_err = 0, otemp = 0, out_oc = 0, in_oc = 0;
  logic [7:0] fan_blocked = 0, fan_slow = 0, iout_a = 0, t_dcdc = 0;
  logic [7:0] t_diss = 0, fan_acdc, fan_dcdc, fan_diss;
  logic [15:0] vout_mv = 0, pout_w = 0;
  logic sinking = 0, is_master = 0, slave_present = 0, link_err = 0;
  logic cfg_mismatch = 0, button = 0, intlk_invert = 0, intlk_ignore = 0;
  logic enable_ignore = 0, reset_ignore = 0, slow = 0, want_en = 0;
  logic want_il = 0, want_rst = 0, enable_contact, intlk_contact;
  logic reset_contact, out_enable, crowbar_on, vref_zero, slave_active;
  logic fault_contact_closed, relay_no_closed, relay_nc_closed;
  logic [9:0] fault_q_o;
  logic [3:0] first_fault;
  logic [7:0] acdc_lo;
  int bad_count = 0, n_tests = 0, seed = 32'he0657285;
  localparam int FB [13] = '{0, 1, 1, 1, 2, 3, 4, 5, 7, 7, 8, 9, 9};

  pfs_supervisor pfs_supervisor_inst (.clk, .rst_n, .bulk_on, .csens_err,
    .bulk_err, .dclink_oc, .crowbar_err, .otemp, .out_oc, .in_oc,
    .fan_blocked, .fan_slow, .vout_mv, .pout_w, .sinking, .iout_a, .t_dcdc,
    .t_diss, .is_master, .slave_present, .link_err, .cfg_mismatch, .button,
    .enable_contact, .intlk_contact, .reset_contact, .intlk_invert,
    .intlk_ignore, .enable_ignore, .reset_ignore, .out_enable, .crowbar_on,
    .vref_zero, .fault_contact_closed, .relay_no_closed, .relay_nc_closed,
    .fault_q_o, .first_fault, .slave_active, .fan_acdc, .fan_dcdc,
    .fan_diss);
  pfs_plant pfs_plant_inst (.clk, .slow, .want_en, .want_il, .want_rst,
    .enable_contact, .intlk_contact, .reset_contact);

  // Clock, 4 ns period
  always #2 clk = ~clk;

  // Expected values
  function automatic logic [9:0] exp_vec(input int c);
    return 10'h001 << FB[c];
  endfunction : exp_vec
  function automatic logic exp_sa(input logic m, p, e);
    return m & p & !e;
  endfunction : exp_sa

  // Compare and count
  task chk(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      bad_count++;
      $display("Error t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : cyc
  // One-cycle closure of the reset contact
  task press_rst;
    @(posedge clk) want_rst <= 1'b1;
    @(posedge clk) want_rst <= 1'b0;
    cyc(6);
  endtask : press_rst
  task press_btn;
    @(posedge clk) button <= 1'b1;
    @(posedge clk) button <= 1'b0;
    cyc(2);
  endtask : press_btn
  // Drive one fault cause by table index
  task cause(input int c, input logic v);
    case (c)
      0: csens_err <= v;
      1: bulk_on <= !v;
      2: bulk_err <= v;
      3: dclink_oc <= v;
      4: crowbar_err <= v;
      5: otemp <= v;
      6: out_oc <= v;
      7: in_oc <= v;
      8: fan_blocked <= {7'h00, v};
      9: fan_slow <= {v, 7'h00};
      10: want_il <= v;
      11: link_err <= v;
      default: cfg_mismatch <= v;
    endcase
  endtask : cause
  task stop_test;
    if (bad_count == 0 && n_tests > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : stop_test

  // Watchdog
  initial begin
    #100000;
    bad_count++;
    stop_test();
  end

  // Main sequence
  initial begin
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    cyc(3);
    chk({out_enable, crowbar_on, vref_zero, relay_nc_closed}, 4'h3);
    for (int c = 0; c < 13; c++) begin
      @(posedge clk) slow <= c[0];
      cause(c, 1'b1);
      cyc(6);
      chk(fault_q_o, exp_vec(c));
      chk(first_fault, 16'(FB[c] + 1));
      chk({fault_contact_closed, crowbar_on, out_enable}, 3'h2);
      press_rst();
      chk(fault_q_o, exp_vec(c));
      @(posedge clk) cause(c, 1'b0);
      press_rst();
      chk({fault_contact_closed, fault_q_o}, 16'h0400);
    end
    @(posedge clk) out_oc <= 1'b1;
    @(posedge clk) csens_err <= 1'b1;
    cyc(2);
    chk(first_fault, 16'(F_OUT_OC + 1));
    @(posedge clk) out_oc <= 1'b0;
    press_rst();
    chk(first_fault, 16'(F_CSENS + 1));
    @(posedge clk) csens_err <= 1'b0;
    press_btn();
    chk({fault_q_o, crowbar_on}, 16'h0000);
    press_btn();
    chk(crowbar_on, 1'b0);
    @(posedge clk) vout_mv <= OV_MV + 16'h0001;
    @(posedge clk) vout_mv <= OV_MV;
    cyc(3);
    chk({fault_q_o[F_CROWBAR], crowbar_on}, 2'h3);
    press_rst();
    @(posedge clk) want_en <= 1'b1;
    cyc(6);
    chk({fault_q_o, crowbar_on}, 16'h0000);
    @(posedge clk) {intlk_ignore, want_il, want_en} <= 3'h6;
    cyc(6);
    chk(fault_q_o, 16'h0000);
    @(posedge clk) intlk_ignore <= 1'b0;
    cyc(6);
    chk(fault_q_o[F_EXTIL], 1'b1);
    @(posedge clk) {intlk_invert, want_il, reset_ignore} <= 3'h5;
    press_rst();
    chk(fault_q_o[F_EXTIL], 1'b1);
    @(posedge clk) intlk_invert <= 1'b0;
    press_rst();
    chk(fault_q_o[F_EXTIL], 1'b1);
    @(posedge clk) reset_ignore <= 1'b0;
    press_rst();
    chk(fault_q_o, 16'h0000);
    @(posedge clk) {enable_ignore, want_en} <= 2'h3;
    cyc(6);
    chk(crowbar_on, 1'b1);
    @(posedge clk) t_diss <= 8'h20;
    cyc(3);
    chk({fan_dcdc, fan_diss}, 16'h0000);
    @(posedge clk) {iout_a, t_dcdc} <= {I_FULL_A, T_DCDC_ON + 8'h01};
    cyc(3);
    chk(fan_dcdc, FAN_MAX);
    chk(fan_acdc !== FAN_ZERO, 1'b1);
    acdc_lo = fan_acdc;
    @(posedge clk) pout_w <= P_BAND_W;
    cyc(3);
    chk(fan_acdc > acdc_lo, 1'b1);
    chk(fault_q_o[F_OPOWER], 1'b0);
    repeat (200) begin
      @(posedge clk) begin
        {is_master, slave_present, link_err} <= 3'($random(seed));
        {sinking, iout_a, t_diss} <= 17'($random(seed));
      end
      cyc(2);
      chk(slave_active, exp_sa(is_master, slave_present, link_err));
      if (sinking || t_diss > T_DISS_ON || t_diss < T_FAN_OFF) begin
        chk(fan_diss != FAN_ZERO, sinking || t_diss > T_DISS_ON);
      end
    end
    stop_test();
  end
endmodule : tb_pfs_supervisor

bind pfs_supervisor pfs_supervisor_checker pfs_supervisor_checker_inst (
  .clk, .rst_n, .bulk_on, .csens_err, .vout_mv, .fan_blocked,
  .intlk_contact, .intlk_invert, .intlk_ignore, .button, .reset_contact,
  .out_enable, .crowbar_on, .vref_zero, .fault_contact_closed,
  .relay_no_closed, .relay_nc_closed, .fault_q_o, .first_fault);
`default_nettype wire
